/* File: design/csv_supervisor.sv */
// Control board supervisor: program watchdog, safe state, supply monitor.
// Assumes one 50 MHz board clock, a classic Wishbone master and
// supply comparators whose outputs are synchronous to the clock.
//
// Notes on behaviour
// RULE_01: Watchdog supervises program servicing, trips on failure.
// RULE_02: Tripped watchdog blocks all flash program writes.
// RULE_03: Trip resets firing control, keeps firing disabled.
// RULE_04: Trip forces every digital output low.
// RULE_05: Trip loads zero into all analogue settings.
// RULE_06: Primary and secondary supply-fail inputs are monitored.
// RULE_07: Any rail below threshold raises trip signal; a low 5 V rail gives master reset instead, which holds the supply trip low.
// RULE_08: Low 5 V rail forces hardware master reset.
// RULE_09: Master reset clears I/O registers, suppresses firing.
// RULE_10: Watchdog trip latches until master reset.
// RULE_11: Program services watchdog well within timeout.
`timescale 1ns/1ps
`include "csv_defs.svh"

module csv_supervisor
   import csv_pkg::*;
#(
   parameter int WDT_CYCLES = `CSV_WDT_TIMEOUT_US * `CSV_CLK_MHZ,
   parameter int DOUT_W = 8,
   parameter int ANA_N = 2,
   parameter int ANA_W = 12
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic pf_primary_i,
   input wire logic pf_secondary_i,
   input wire logic rail5v_low_i,
   input wire logic flash_wr_req_i,
   output logic flash_wr_en_o,
   output logic fire_en_o,
   output logic fire_rst_o,
   output logic [DOUT_W-1:0] dout_o,
   output logic [ANA_N*ANA_W-1:0] aout_o,
   output logic supply_trip_o,
   output logic master_rst_o,
   output logic irq_o
);

   localparam int CNT_W = $clog2(WDT_CYCLES + 1);
   localparam logic [CNT_W-1:0] WDT_LOAD = CNT_W'(WDT_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   // Index width, number of analogue slots in the address window, bus word width.
   localparam int AIDX_W = `CSV_AOUT_IDX_MSB - `CSV_AOUT_IDX_LSB + 1;
   localparam int ANA_MAX = 1 << AIDX_W;
   localparam int WORD_W = $bits(csv_word_t);

   // A counter of fewer than two cycles cannot tell a service from a miss.
   if (WDT_CYCLES < 2) begin : g_bad_timeout
      $error("csv_supervisor: watchdog timeout below two cycles");
   end
   // Outputs wider than a bus word could not be written or read back.
   if (DOUT_W < 1 || DOUT_W > WORD_W || ANA_W < 1 || ANA_W > WORD_W) begin : g_bad_width
      $error("csv_supervisor: output width outside one bus word");
   end
   // The analogue window holds a fixed number of word slots.
   if (ANA_N < 1 || ANA_N > ANA_MAX) begin : g_bad_count
      $error("csv_supervisor: analogue setting count outside the window");
   end

   // Merges a write word into a register under the byte enables.
   function automatic csv_word_t merge(input csv_word_t old_v,
                                       input csv_word_t new_v,
                                       input logic [3:0] sel);
      csv_word_t res;
      res = old_v;
      for (int b = 0; b < `CSV_SEL_W; b++) begin
         if (sel[b]) begin
            res[`CSV_BYTE_W*b +: `CSV_BYTE_W] = new_v[`CSV_BYTE_W*b +: `CSV_BYTE_W];
         end
      end
      return res;
   endfunction

   // Tells whether the bus index selects analogue setting idx.
   function automatic logic aout_sel(input logic [AIDX_W-1:0] a, input int idx);
      return int'(a) == idx;
   endfunction

   // Registers.
   csv_wd_e wd_r;
   csv_wd_e wd_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic [`CSV_CTRL_W-1:0] ctrl_r;
   logic [`CSV_CTRL_W-1:0] ctrl_nxt;
   logic [`CSV_IRQ_W-1:0] ist_r;
   logic [`CSV_IRQ_W-1:0] ist_nxt;
   logic [`CSV_IRQ_W-1:0] imask_r;
   logic [`CSV_IRQ_W-1:0] imask_nxt;
   logic [DOUT_W-1:0] dout_r;
   logic [DOUT_W-1:0] dout_nxt;
   logic [ANA_W-1:0] aout_r [ANA_N];
   logic [ANA_W-1:0] aout_nxt [ANA_N];
   logic ack_r;
   csv_word_t dat_r;
   logic flash_en_r;
   logic fire_en_r;
   logic fire_rst_r;
   logic supply_r;
   logic mrst_r;
   logic irq_r;

   // Bus decode. A request is taken while no ack stands; a write acts at the
   // edge that ends the ack cycle, which is where the master samples ack high.
   wire logic req = wb_cyc_i & wb_stb_i & ~ack_r;
   wire logic wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
   wire logic hit_ctrl = wb_adr_i == `CSV_ADR_CTRL;
   wire logic hit_kick = wb_adr_i == `CSV_ADR_KICK;
   wire logic hit_stat = wb_adr_i == `CSV_ADR_STATUS;
   wire logic hit_ist = wb_adr_i == `CSV_ADR_IRQ_STAT;
   wire logic hit_imask = wb_adr_i == `CSV_ADR_IRQ_MASK;
   wire logic hit_dout = wb_adr_i == `CSV_ADR_DOUT;
   wire logic [AIDX_W-1:0] aidx = wb_adr_i[`CSV_AOUT_IDX_MSB:`CSV_AOUT_IDX_LSB];
   wire logic hit_aout = ((wb_adr_i & `CSV_ADR_AOUT_MASK) == `CSV_ADR_AOUT_BASE) &
                         (int'(aidx) < ANA_N);

   // Master reset: board reset or the 5 V rail below its trip level.
   // A one-cycle dip of the rail flag still clears everything but the bus answer, erring on
   // the safe side rather than filtering it.
   wire logic mrst = rst_i | rail5v_low_i; // [RULE_08]

   // Watchdog service decode: only the full key written as one word counts.
   // A wrong key trips at once, so a runaway program that scribbles over the
   // register map cannot keep the watchdog alive by accident.
   wire logic kick_wr = wr & hit_kick;
   wire logic kick_ok = kick_wr & (wb_sel_i == `CSV_SEL_ALL) &
                        (wb_dat_i == `CSV_KICK_KEY);
   wire logic kick_bad = kick_wr & ~kick_ok;
   wire logic trip = wd_r == CSV_WD_TRIP;
   wire logic running = wd_r == CSV_WD_RUN;

   // Control word: the watchdog enable is sticky once set by software.
   wire csv_word_t ctrl_wv = merge(32'(ctrl_r), wb_dat_i, wb_sel_i);
   wire logic wdt_en_nxt = ctrl_r[`CSV_CTRL_WDT_EN] |
                           (wr & hit_ctrl & ctrl_wv[`CSV_CTRL_WDT_EN]);

   // Watchdog state machine; a trip is left only by master reset.
   always_comb begin
      wd_nxt = wd_r;
      case (wd_r)
         CSV_WD_OFF: begin
            if (wdt_en_nxt) begin
               wd_nxt = CSV_WD_RUN;
            end
         end
         CSV_WD_RUN: begin
            if (cnt_r == CNT_ZERO || kick_bad) begin
               wd_nxt = CSV_WD_TRIP; // [RULE_01]
            end
         end
         CSV_WD_TRIP: begin
            wd_nxt = CSV_WD_TRIP; // [RULE_10]
         end
         default: begin
            wd_nxt = CSV_WD_TRIP;
         end
      endcase
   end

   wire logic trip_evt = running & (wd_nxt == CSV_WD_TRIP);

   // Safe state: tripped already, or tripping at this edge.
   wire logic safe = trip | trip_evt;

   // Timeout counter: reloaded by a correct service, counts while running.
   assign cnt_nxt = (!running || kick_ok) ? WDT_LOAD : // [RULE_01]
                    (cnt_r - CNT_W'(1));

   // Firing enable is dropped at a trip and cannot be set while tripped.
   always_comb begin
      ctrl_nxt = ctrl_r;
      ctrl_nxt[`CSV_CTRL_WDT_EN] = wdt_en_nxt;
      if (wr && hit_ctrl) begin
         ctrl_nxt[`CSV_CTRL_FIRE_EN] = ctrl_wv[`CSV_CTRL_FIRE_EN];
      end
      if (safe) begin
         ctrl_nxt[`CSV_CTRL_FIRE_EN] = 1'b0; // [RULE_03]
      end
   end

   // Digital outputs: zero in the safe state, writes ignored meanwhile.
   wire csv_word_t dout_wv = merge(32'(dout_r), wb_dat_i, wb_sel_i);
   assign dout_nxt = safe ? '0 : // [RULE_04]
                     (wr && hit_dout) ? dout_wv[DOUT_W-1:0] : dout_r;

   // Analogue settings: loaded with zero in the safe state.
   always_comb begin
      csv_word_t av;
      av = `CSV_ZERO_WORD;
      for (int i = 0; i < ANA_N; i++) begin
         aout_nxt[i] = aout_r[i];
         av = merge(32'(aout_r[i]), wb_dat_i, wb_sel_i);
         if (wr && hit_aout && aout_sel(aidx, i)) begin
            aout_nxt[i] = av[ANA_W-1:0];
         end
         if (safe) begin
            aout_nxt[i] = '0; // [RULE_05]
         end
      end
   end

   // Supply fail indications from both monitors.
   wire logic supply_now = pf_primary_i | pf_secondary_i; // [RULE_06]
   wire logic supply_evt = supply_now & ~supply_r;

   // Flash writes pass only while the watchdog is not tripped.
   // The gate adds one edge of delay, so a request must stand until it is seen.
   wire logic flash_ok = flash_wr_req_i & ~safe; // [RULE_02]
   wire logic flash_blk = flash_wr_req_i & safe;

   // Interrupt status: a set in the same cycle wins over a one-written clear,
   // so an event is never lost to a clear that software wrote just before it.
   wire logic [`CSV_IRQ_W-1:0] ev = {flash_blk, supply_evt, trip_evt};
   wire logic [`CSV_IRQ_W-1:0] clr = (wr && hit_ist) ?
                                     wb_dat_i[`CSV_IRQ_W-1:0] : '0;
   assign ist_nxt = (ist_r & ~clr) | ev;
   assign imask_nxt = (wr && hit_imask) ?
                      wb_dat_i[`CSV_IRQ_W-1:0] : imask_r;

   // Read data multiplexer; unmapped addresses read as zero.
   // Status shows the live fail inputs beside the registered supply trip.
   csv_word_t rdata;
   csv_word_t status_w;
   always_comb begin
      status_w = `CSV_ZERO_WORD;
      status_w[`CSV_ST_TRIPPED] = trip;
      status_w[`CSV_ST_PF_PRI] = pf_primary_i;
      status_w[`CSV_ST_PF_SEC] = pf_secondary_i;
      status_w[`CSV_ST_SUPPLY] = supply_r;
      status_w[`CSV_ST_RUNNING] = running;
      rdata = `CSV_ZERO_WORD;
      if (hit_ctrl) begin
         rdata = 32'(ctrl_r);
      end else if (hit_stat) begin
         rdata = status_w;
      end else if (hit_ist) begin
         rdata = 32'(ist_r);
      end else if (hit_imask) begin
         rdata = 32'(imask_r);
      end else if (hit_dout) begin
         rdata = 32'(dout_r);
      end else if (hit_aout) begin
         for (int i = 0; i < ANA_N; i++) begin
            if (aout_sel(aidx, i)) begin
               rdata = 32'(aout_r[i]);
            end
         end
      end
   end

   // Bus answer: one-cycle ack, read data registered with it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= `CSV_ZERO_WORD;
      end else begin
         ack_r <= req;
         dat_r <= req ? rdata : `CSV_ZERO_WORD;
      end
   end

   // Watchdog and control state, cleared by any master reset; the counter reloads.
   always_ff @(posedge clk_i) begin
      if (mrst) begin
         wd_r <= CSV_WD_OFF; // [RULE_10]
         cnt_r <= WDT_LOAD;
         ctrl_r <= '0;
         ist_r <= '0;
         imask_r <= '0;
      end else begin
         wd_r <= wd_nxt;
         cnt_r <= cnt_nxt;
         ctrl_r <= ctrl_nxt;
         ist_r <= ist_nxt;
         imask_r <= imask_nxt;
      end
   end

   // Input/output registers, forced to zero by master reset.
   always_ff @(posedge clk_i) begin
      if (mrst) begin
         dout_r <= '0; // [RULE_09]
         for (int i = 0; i < ANA_N; i++) begin
            aout_r[i] <= '0; // [RULE_09]
         end
      end else begin
         dout_r <= dout_nxt;
         for (int i = 0; i < ANA_N; i++) begin
            aout_r[i] <= aout_nxt[i];
         end
      end
   end

   // Output flops for firing, flash gate, supply trip and interrupt.
   // Firing drops at the very edge that detects a trip, not one edge later.
   always_ff @(posedge clk_i) begin
      if (mrst) begin
         fire_en_r <= 1'b0; // [RULE_09]
         fire_rst_r <= 1'b1; // [RULE_09]
         flash_en_r <= 1'b0;
         supply_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         fire_en_r <= ctrl_nxt[`CSV_CTRL_FIRE_EN] & ~safe; // [RULE_03]
         fire_rst_r <= safe; // [RULE_03]
         flash_en_r <= flash_ok; // [RULE_02]
         supply_r <= supply_now; // [RULE_07]
         irq_r <= |(ist_nxt & imask_nxt);
      end
   end

   // Master reset indication follows the reset sources by one edge.
   always_ff @(posedge clk_i) begin
      mrst_r <= mrst; // [RULE_08]
   end

   // Port assignments from flops.
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign flash_wr_en_o = flash_en_r;
   assign fire_en_o = fire_en_r;
   assign fire_rst_o = fire_rst_r;
   assign dout_o = dout_r;
   assign supply_trip_o = supply_r;
   assign master_rst_o = mrst_r;
   assign irq_o = irq_r;

   // Analogue settings packed onto the output bus, setting 0 lowest.
   for (genvar g = 0; g < ANA_N; g++) begin : g_aout
      assign aout_o[g*ANA_W +: ANA_W] = aout_r[g];
   end

endmodule // csv_supervisor

/* File: design/csv_defs.svh */
// Constants of the control board supervisor: register map, fields, timing.
// Assumes inclusion by its bare name from the supervisor package and module.
`ifndef CSV_DEFS_SVH
`define CSV_DEFS_SVH

// Byte offsets of the Wishbone registers.
`define CSV_ADR_CTRL 8'h00
`define CSV_ADR_KICK 8'h04
`define CSV_ADR_STATUS 8'h08
`define CSV_ADR_IRQ_STAT 8'h0C
`define CSV_ADR_IRQ_MASK 8'h10
`define CSV_ADR_DOUT 8'h14
`define CSV_ADR_AOUT_BASE 8'h20
`define CSV_ADR_AOUT_MASK 8'hE0
`define CSV_AOUT_IDX_MSB 4
`define CSV_AOUT_IDX_LSB 2

// Control bits.
`define CSV_CTRL_WDT_EN 0
`define CSV_CTRL_FIRE_EN 1
`define CSV_CTRL_W 2

// Status bits.
`define CSV_ST_TRIPPED 0
`define CSV_ST_PF_PRI 1
`define CSV_ST_PF_SEC 2
`define CSV_ST_SUPPLY 3
`define CSV_ST_RUNNING 4

// Interrupt status and mask bits.
`define CSV_IRQ_WDT 0
`define CSV_IRQ_SUPPLY 1
`define CSV_IRQ_FLASH 2
`define CSV_IRQ_W 3

// Service key and reset values.
`define CSV_KICK_KEY 32'h0000_5A5A
`define CSV_ZERO_WORD 32'h0000_0000
`define CSV_SEL_ALL 4'hF

// Bus word layout: byte lanes and their width.
`define CSV_BYTE_W 8
`define CSV_SEL_W 4

// Watchdog timeout and board clock.
`define CSV_WDT_TIMEOUT_US 1000
`define CSV_CLK_MHZ 50

// Rail trip levels in millivolts, applied by the external comparators.
`define CSV_TRIP_5V_MV 4550
`define CSV_TRIP_15V_MV 12400
`define CSV_TRIP_48V_MV 38000

`endif

/* File: design/csv_pkg.sv */
// Types shared by the control board supervisor.
// Assumes the constants header sits in the include path.
`include "csv_defs.svh"

package csv_pkg;

   // Watchdog states.
   typedef enum logic [1:0] {
      CSV_WD_OFF,
      CSV_WD_RUN,
      CSV_WD_TRIP
   } csv_wd_e;

   // One bus word.
   typedef logic [31:0] csv_word_t;

endpackage

/* File: verification/csv_supervisor_properties.sv */
// Concurrent checks on the supervisor ports.
// Assumes binding to csv_supervisor with its own parameters.
`timescale 1ns/1ps
module csv_sup_checker #(
   parameter int WDT_CYCLES = 16,
   parameter int DOUT_W = 8,
   parameter int ANA_N = 2,
   parameter int ANA_W = 12
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic pf_primary_i,
   input wire logic pf_secondary_i,
   input wire logic rail5v_low_i,
   input wire logic flash_wr_req_i,
   input wire logic flash_wr_en_o,
   input wire logic fire_en_o,
   input wire logic fire_rst_o,
   input wire logic [DOUT_W-1:0] dout_o,
   input wire logic [ANA_N*ANA_W-1:0] aout_o,
   input wire logic supply_trip_o,
   input wire logic master_rst_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // The safe state forces every output that firing and flash depend on.
   a_flash_blocked: assert property (fire_rst_o |-> !flash_wr_en_o && !fire_en_o)
      else $error("flash or firing enabled in safe state");
   a_flash_follows: assert property (flash_wr_en_o |-> $past(flash_wr_req_i))
      else $error("flash enable without request");
   a_safe_dout: assert property (fire_rst_o |-> dout_o == '0)
      else $error("digital outputs not low in safe state");
   a_safe_aout: assert property (fire_rst_o |-> aout_o == '0)
      else $error("analogue settings not zero in safe state");
   // A trip may only be left through a master reset.
   a_trip_latch: assert property (fire_rst_o && !master_rst_o && !rail5v_low_i |=> fire_rst_o)
      else $error("trip released without master reset");
   a_supply_trip: assert property (!master_rst_o |-> supply_trip_o == $past(pf_primary_i | pf_secondary_i))
      else $error("supply trip does not follow fail inputs");
   a_rail_reset: assert property (rail5v_low_i |=> master_rst_o && fire_rst_o && dout_o == '0 && aout_o == '0)
      else $error("low 5 V rail did not force master reset");
   // Each request is answered by one single-cycle acknowledge.
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not acknowledged");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   c_rail: cover property (rail5v_low_i);
   c_trip: cover property ($rose(fire_rst_o) && !master_rst_o);
   c_supply: cover property ($rose(supply_trip_o));
endmodule // csv_sup_checker

bind csv_supervisor csv_sup_checker #(.WDT_CYCLES(WDT_CYCLES), .DOUT_W(DOUT_W), .ANA_N(ANA_N), .ANA_W(ANA_W))
   u_chk (.*);

/* File: verification/csv_rail_model.sv */
// Supply comparator model: turns rail readings into fail levels.
// Assumes millivolt readings set by the bench at the rising edge.
`timescale 1ns/1ps
`include "csv_defs.svh"
module csv_rail_model (
   input wire logic clk_i,
   input wire logic pri_ok_i,
   input wire logic [15:0] mv5_i,
   input wire logic [15:0] mv15_i,
   input wire logic [15:0] mv48_i,
   output logic pf_primary_o,
   output logic pf_secondary_o,
   output logic rail5v_low_o
);
   // Comparators register their verdict, since real ones settle slowly.
   always_ff @(posedge clk_i) begin
      pf_primary_o <= !pri_ok_i;
      pf_secondary_o <= (mv15_i < `CSV_TRIP_15V_MV) || (mv48_i < `CSV_TRIP_48V_MV);
      rail5v_low_o <= mv5_i < `CSV_TRIP_5V_MV;
   end
endmodule // csv_rail_model

/* File: verification/csv_supervisor_bench.sv */
// Self-checking bench of the supervisor over classic Wishbone.
// Assumes the rail model in place of the supply comparators.
`timescale 1ns/1ps
`include "csv_defs.svh"
`define CSV_CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin $display("mismatch %s exp %h got %h", n, e, a); miscompares++; end end
module csv_supervisor_bench;
   import csv_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, flash_wr_req_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   csv_word_t wb_dat_i = '0, wb_dat_o, rd;
   logic wb_ack_o, pf_primary_i, pf_secondary_i, rail5v_low_i, flash_wr_en_o, fire_en_o, fire_rst_o;
   logic supply_trip_o, master_rst_o, irq_o, pri_ok = 1'b1;
   logic [7:0] dout_o;
   logic [23:0] aout_o;
   logic [15:0] mv5 = 16'(`CSV_TRIP_5V_MV + 100), mv15 = 16'(`CSV_TRIP_15V_MV + 100), mv48 = 16'(`CSV_TRIP_48V_MV);
   int miscompares = 0, n_tests = 0;

   csv_supervisor #(.WDT_CYCLES(16), .DOUT_W(8), .ANA_N(2), .ANA_W(12)) dut (.*);
   csv_rail_model u_rails (.clk_i(clk_i), .pri_ok_i(pri_ok), .mv5_i(mv5), .mv15_i(mv15), .mv48_i(mv48),
      .pf_primary_o(pf_primary_i), .pf_secondary_o(pf_secondary_i), .rail5v_low_o(rail5v_low_i));

   // Free-running board clock.
   always #10 clk_i = ~clk_i;

   task automatic print_verdict();
      if (miscompares == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // One classic cycle; holds the request until ack is sampled high.
   task automatic wb(input logic we, input logic [7:0] adr, input csv_word_t dat);
      int i = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= `CSV_SEL_ALL;
      wb_dat_i <= dat;
      do begin
         @(posedge clk_i);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 20);
      if (wb_ack_o !== 1'b1) begin
         miscompares++;
         print_verdict();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic rdchk(input string n, input logic [7:0] adr, input csv_word_t mask, input csv_word_t exp);
      wb(1'b0, adr, '0);
      `CSV_CHK(n, exp, rd & mask)
   endtask

   // Lets n edges pass, then samples in the settled half of the cycle.
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   task automatic wait_trip(input int lim);
      int i = 0;
      while (fire_rst_o !== 1'b1 && i < lim) begin
         @(posedge clk_i);
         i++;
      end
      `CSV_CHK("trip", 1'b1, fire_rst_o)
   endtask

   // Main sequence: normal run, trip, supply fail, rail reset, bad service.
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      settle(2);
      rdchk("ctrl", `CSV_ADR_CTRL, '1, '0);
      rdchk("unmapped", 8'h1C, '1, '0);
      rdchk("status", `CSV_ADR_STATUS, '1, '0);
      wb(1'b1, `CSV_ADR_DOUT, 32'h0000_00A5);
      wb(1'b1, `CSV_ADR_AOUT_BASE, 32'h0000_0123);
      wb(1'b1, 8'h24, 32'h0000_0ABC);
      wb(1'b1, `CSV_ADR_CTRL, 32'h0000_0003);
      flash_wr_req_i <= 1'b1;
      settle(2);
      `CSV_CHK("dout", 8'hA5, dout_o)
      `CSV_CHK("aout", 24'hABC_123, aout_o)
      `CSV_CHK("fire", 1'b1, fire_en_o)
      `CSV_CHK("flash", 1'b1, flash_wr_en_o)
      repeat (6) wb(1'b1, `CSV_ADR_KICK, `CSV_KICK_KEY);
      repeat (10) @(posedge clk_i);
      `CSV_CHK("early", 1'b0, fire_rst_o)
      wait_trip(16);
      settle(1);
      `CSV_CHK("dout0", 8'h00, dout_o)
      `CSV_CHK("aout0", 24'h000_000, aout_o)
      `CSV_CHK("fire0", 1'b0, fire_en_o)
      `CSV_CHK("flash0", 1'b0, flash_wr_en_o)
      wb(1'b1, `CSV_ADR_DOUT, 32'h0000_00FF);
      wb(1'b1, `CSV_ADR_CTRL, 32'h0000_0002);
      settle(1);
      `CSV_CHK("dout_held", 8'h00, dout_o)
      `CSV_CHK("fire_held", 1'b0, fire_en_o)
      rdchk("st_trip", `CSV_ADR_STATUS, 32'h0000_000F, 32'h0000_0001);
      rdchk("irq_st", `CSV_ADR_IRQ_STAT, '1, 32'h0000_0005);
      `CSV_CHK("irq_masked", 1'b0, irq_o)
      wb(1'b1, `CSV_ADR_IRQ_MASK, 32'h0000_0007);
      settle(1);
      `CSV_CHK("irq_on", 1'b1, irq_o)
      @(posedge clk_i);
      flash_wr_req_i <= 1'b0;
      wb(1'b1, `CSV_ADR_IRQ_STAT, 32'h0000_0007);
      settle(1);
      `CSV_CHK("irq_clr", 1'b0, irq_o)
      @(posedge clk_i);
      pri_ok <= 1'b0;
      mv15 <= 16'(`CSV_TRIP_15V_MV - 1);
      settle(3);
      `CSV_CHK("supply", 1'b1, supply_trip_o)
      `CSV_CHK("irq_sup", 1'b1, irq_o)
      rdchk("st_sup", `CSV_ADR_STATUS, 32'h0000_000E, 32'h0000_000E);
      pri_ok <= 1'b1;
      mv15 <= 16'(`CSV_TRIP_15V_MV);
      settle(3);
      `CSV_CHK("supply_ok", 1'b0, supply_trip_o)
      `CSV_CHK("latched", 1'b1, fire_rst_o)
      @(posedge clk_i);
      mv5 <= 16'(`CSV_TRIP_5V_MV - 1);
      settle(3);
      `CSV_CHK("mrst", 1'b1, master_rst_o)
      @(posedge clk_i);
      mv5 <= 16'(`CSV_TRIP_5V_MV);
      settle(4);
      `CSV_CHK("mrst_off", 1'b0, master_rst_o)
      `CSV_CHK("untrip", 1'b0, fire_rst_o)
      `CSV_CHK("irq_rst", 1'b0, irq_o)
      rdchk("ctrl_rst", `CSV_ADR_CTRL, '1, '0);
      rdchk("mask_rst", `CSV_ADR_IRQ_MASK, '1, '0);
      wb(1'b1, `CSV_ADR_DOUT, 32'h0000_003C);
      wb(1'b1, `CSV_ADR_AOUT_BASE, 32'h0000_0055);
      wb(1'b1, `CSV_ADR_CTRL, 32'h0000_0002);
      settle(1);
      `CSV_CHK("fire_on", 1'b1, fire_en_o)
      `CSV_CHK("dout_on", 8'h3C, dout_o)
      `CSV_CHK("aout_on", 24'h000_055, aout_o)
      @(posedge clk_i);
      mv5 <= 16'(`CSV_TRIP_5V_MV - 1);
      settle(3);
      `CSV_CHK("dout_rst", 8'h00, dout_o)
      `CSV_CHK("aout_rst", 24'h000_000, aout_o)
      `CSV_CHK("fire_rst", 1'b0, fire_en_o)
      `CSV_CHK("fire_ctl", 1'b1, fire_rst_o)
      @(posedge clk_i);
      mv5 <= 16'(`CSV_TRIP_5V_MV);
      settle(4);
      `CSV_CHK("mrst_rel", 1'b0, master_rst_o)
      wb(1'b1, `CSV_ADR_CTRL, 32'h0000_0001);
      wb(1'b1, `CSV_ADR_KICK, 32'h0000_1234);
      wait_trip(4);
      print_verdict();
   end
endmodule // csv_supervisor_bench
